/* inc/dahr_pkg.sv */
// Constants and types for the automatic-access DRAM controller with hidden refresh.
// Assumes a single 125 MHz clock; all pins sampled synchronously to it.
package dahr_pkg;
  // Address width and bank count
  localparam int ADDR_W = 9;
  localparam int BANKS = 4;
  // Clock period in picoseconds
  localparam int CLK_PS = 8000;
  // Row hold times in picoseconds, long (select high) and short
  localparam int ROW_HOLD_LONG_PS = 15000;
  localparam int ROW_HOLD_SHORT_PS = 8000;
  // Least times round up to whole cycles
  localparam logic [3:0] ROW_HOLD_LONG_CYC = 4'((ROW_HOLD_LONG_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] ROW_HOLD_SHORT_CYC = 4'((ROW_HOLD_SHORT_PS + CLK_PS - 1) / CLK_PS);
  // Refresh mode select values
  localparam logic REFRESH_MODE_EXTERNAL = 1'b0;
  localparam logic REFRESH_MODE_AUTO = 1'b1;
  // Reset values
  localparam logic [8:0] REFRESH_COUNT_RESET = 9'h000;
  // Auto refresh generation falling-edge counts
  localparam logic [2:0] AUTO_FALL_START = 3'h2;
  localparam logic [2:0] AUTO_FALL_END = 3'h4;
  // Access sequencer states
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_ROW,
    ACC_COL
  } dahr_acc_type;
endpackage : dahr_pkg

/* rtl/dahr_ctrl.sv */
// DRAM controller: automatic access, hidden refresh, refresh request, forced refresh.
// Assumes all inputs are synchronous to clk; slow clocks are sampled and edge-detected.
`timescale 1ns/1ps
module dahr_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Address inputs
  input wire logic [8:0] row_addr_in,
  input wire logic [8:0] col_addr_in,
  input wire logic bank_sel_lo,
  input wire logic bank_sel_hi,
  input wire logic address_latch_strobe,
  // Access control
  input wire logic access_request_in_n,
  input wire logic write_request_in_n,
  input wire logic chip_select_n,
  input wire logic row_hold_select,
  // Refresh control
  input wire logic refresh_period_clock,
  input wire logic refresh_gen_clock,
  input wire logic refresh_mode_n,
  input wire logic refresh_mode_select,
  // DRAM outputs
  output logic [8:0] dram_addr_out,
  output logic [3:0] row_strobe_n,
  output logic col_strobe_n,
  output logic write_strobe_n,
  // Refresh request pin, driven low only (open drain)
  output logic refresh_request_out,
  output logic refresh_request_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Address latches
  ////////////////////////////////////////////////////////////////////////////
  logic [8:0] row_lat_q, row_lat_d; // Held row address
  logic [8:0] col_lat_q, col_lat_d; // Held column address
  logic [1:0] bank_lat_q, bank_lat_d; // Held bank select
  logic [8:0] row_eff; // Row address in use
  logic [8:0] col_eff; // Column address in use
  logic [1:0] bank_eff; // Bank in use

  always_comb begin
    row_lat_d = row_lat_q;
    col_lat_d = col_lat_q;
    bank_lat_d = bank_lat_q;
    if (address_latch_strobe) begin
      row_lat_d = row_addr_in;
      col_lat_d = col_addr_in;
      bank_lat_d = {bank_sel_hi, bank_sel_lo};
    end
    // Fall through while strobe is high
    row_eff = address_latch_strobe ? row_addr_in : row_lat_q;
    col_eff = address_latch_strobe ? col_addr_in : col_lat_q;
    bank_eff = address_latch_strobe ? {bank_sel_hi, bank_sel_lo} : bank_lat_q;
  end

  // Latch registers
  always_ff @(posedge clk) begin
    if (rst) begin
      row_lat_q <= 9'h000;
      col_lat_q <= 9'h000;
      bank_lat_q <= 2'h0;
    end else begin
      row_lat_q <= row_lat_d;
      col_lat_q <= col_lat_d;
      bank_lat_q <= bank_lat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input edge detection
  ////////////////////////////////////////////////////////////////////////////
  logic pclk_q; // Previous refresh clock
  logic gclk_q; // Previous generation clock
  logic req_in_q; // Previous access request
  logic mode_q; // Previous refresh mode
  logic pclk_fall, gclk_fall, req_rise, mode_entry;

  // Previous-value registers; slow clocks tracked in reset, so no false edge on release
  always_ff @(posedge clk) begin
    if (rst) begin
      pclk_q <= refresh_period_clock;
      gclk_q <= refresh_gen_clock;
      req_in_q <= 1'b1;
      mode_q <= 1'b1;
    end else begin
      pclk_q <= refresh_period_clock;
      gclk_q <= refresh_gen_clock;
      req_in_q <= access_request_in_n;
      mode_q <= refresh_mode_n;
    end
  end

  // Edge pulses
  always_comb begin
    pclk_fall = pclk_q & ~refresh_period_clock;
    gclk_fall = gclk_q & ~refresh_gen_clock;
    req_rise = ~req_in_q & access_request_in_n;
    mode_entry = mode_q & ~refresh_mode_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh state
  ////////////////////////////////////////////////////////////////////////////
  logic [8:0] rcnt_q, rcnt_d; // Refresh row counter
  logic hid_q, hid_d; // Hidden refresh in progress
  logic done_q, done_d; // Refresh done this period
  logic pend_q, pend_d; // Refresh request pending
  logic [2:0] falls_q, falls_d; // Generation clock falls in auto mode
  logic auto_low; // Auto refresh strobes low
  logic hid_ok; // Hidden refresh conditions met
  logic ext_mode, auto_mode;

  // Refresh next-state logic
  always_comb begin
    ext_mode = ~refresh_mode_n & (refresh_mode_select == dahr_pkg::REFRESH_MODE_EXTERNAL);
    auto_mode = ~refresh_mode_n & (refresh_mode_select == dahr_pkg::REFRESH_MODE_AUTO);
    hid_ok = refresh_mode_n & chip_select_n & refresh_period_clock & ~done_q;
    rcnt_d = rcnt_q;
    hid_d = hid_q;
    done_d = done_q;
    pend_d = pend_q;
    falls_d = falls_q;
    if (hid_ok && !access_request_in_n) begin
      hid_d = 1'b1;
      done_d = 1'b1;
    end
    if (hid_q && req_rise) begin
      hid_d = 1'b0;
    end
    if (req_rise && (hid_q || ext_mode)) begin
      rcnt_d = 9'(rcnt_q + 9'h001);
    end
    if (!auto_mode) begin
      falls_d = 3'h0;
    end else if (gclk_fall && falls_q != dahr_pkg::AUTO_FALL_END) begin
      falls_d = 3'(falls_q + 3'h1);
      if (3'(falls_q + 3'h1) == dahr_pkg::AUTO_FALL_END) begin
        rcnt_d = 9'(rcnt_q + 9'h001);
      end
    end
    // Period restarts when refresh clock falls; request if nothing refreshed
    if (pclk_fall) begin
      if (!done_q && !hid_q) begin
        pend_d = 1'b1;
      end
      done_d = 1'b0;
    end
    if (ext_mode) begin
      pend_d = 1'b0;
    end
    if (auto_low) begin
      pend_d = 1'b0;
    end
    // Forced refresh entered while period clock high counts as its refresh
    if (mode_entry && refresh_period_clock) begin
      done_d = 1'b1;
    end
  end

  // Strobes low between second and fourth fall; release via auto_mode
  assign auto_low = auto_mode && falls_q >= dahr_pkg::AUTO_FALL_START && falls_q < dahr_pkg::AUTO_FALL_END;

  // Refresh registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rcnt_q <= dahr_pkg::REFRESH_COUNT_RESET;
      hid_q <= 1'b0;
      done_q <= 1'b0;
      pend_q <= 1'b0;
      falls_q <= 3'h0;
    end else begin
      rcnt_q <= rcnt_d;
      hid_q <= hid_d;
      done_q <= done_d;
      pend_q <= pend_d;
      falls_q <= falls_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  ////////////////////////////////////////////////////////////////////////////
  dahr_pkg::dahr_acc_type acc_q, acc_d; // Access phase
  logic [3:0] hold_q, hold_d; // Row hold counter
  logic [3:0] hold_need; // Selected row hold

  // Access next-state logic
  always_comb begin
    hold_need = row_hold_select ? dahr_pkg::ROW_HOLD_LONG_CYC : dahr_pkg::ROW_HOLD_SHORT_CYC;
    acc_d = acc_q;
    hold_d = hold_q;
    unique case (acc_q)
      dahr_pkg::ACC_IDLE: begin
        if (!access_request_in_n && !chip_select_n && refresh_mode_n && !hid_d) begin
          acc_d = dahr_pkg::ACC_ROW;
          hold_d = 4'h1;
        end
      end
      dahr_pkg::ACC_ROW: begin
        if (access_request_in_n) begin
          acc_d = dahr_pkg::ACC_IDLE;
        end else if (hold_q >= hold_need) begin
          acc_d = dahr_pkg::ACC_COL;
        end else begin
          hold_d = 4'(hold_q + 4'h1);
        end
      end
      dahr_pkg::ACC_COL: begin
        if (access_request_in_n) begin
          acc_d = dahr_pkg::ACC_IDLE;
        end
      end
    endcase
  end

  // Access registers
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= dahr_pkg::ACC_IDLE;
      hold_q <= 4'h0;
    end else begin
      acc_q <= acc_d;
      hold_q <= hold_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  ////////////////////////////////////////////////////////////////////////////
  logic [8:0] addr_d;
  logic [3:0] ras_d;
  logic cas_d, we_d, rq_d;

  // Output next values
  always_comb begin
    ras_d = 4'hf;
    addr_d = row_eff;
    cas_d = 1'b1;
    we_d = write_request_in_n;
    if (!refresh_mode_n) begin
      // Counter on address in refresh modes
      addr_d = rcnt_q;
      we_d = 1'b1;
      if (ext_mode) begin
        // System drives strobes in external refresh
        ras_d = {4{access_request_in_n}};
      end else if (auto_low) begin
        ras_d = 4'h0;
      end
    end else if (hid_d) begin
      addr_d = rcnt_q;
      ras_d = {4{access_request_in_n}};
      we_d = 1'b1;
    end else if (acc_d != dahr_pkg::ACC_IDLE) begin
      ras_d[bank_eff] = access_request_in_n;
      if (acc_d == dahr_pkg::ACC_COL) begin
        addr_d = col_eff;
        cas_d = 1'b0;
      end
    end
    // Pin low only while a request is pending
    rq_d = ~pend_d;
  end

  // Output flip-flops
  always_ff @(posedge clk) begin
    if (rst) begin
      dram_addr_out <= 9'h000;
      row_strobe_n <= 4'hf;
      col_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      refresh_request_out <= 1'b1;
      refresh_request_oe <= 1'b0;
    end else begin
      dram_addr_out <= addr_d;
      row_strobe_n <= ras_d;
      col_strobe_n <= cas_d;
      write_strobe_n <= we_d;
      refresh_request_out <= rq_d;
      refresh_request_oe <= ~rq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////
  property p_tied_high;
    @(posedge clk) disable iff (rst) refresh_period_clock [*8] |-> refresh_request_out;
  endproperty
  a_tied_high: assert property (p_tied_high) else $error("request raised with refresh clock high");

  property p_ext_clears;
    @(posedge clk) disable iff (rst) ext_mode |=> refresh_request_out;
  endproperty
  a_ext_clears: assert property (p_ext_clears) else $error("request not released in external mode");

  property p_cas_late;
    @(posedge clk) disable iff (rst) (refresh_mode_n && $fell(col_strobe_n)) |-> $past(row_strobe_n) != 4'hf;
  endproperty
  a_cas_late: assert property (p_cas_late) else $error("column strobe without prior row strobe");

  // No new hidden refresh once this period's refresh is done
  property p_one_hidden;
    @(posedge clk) disable iff (rst) (!hid_q && done_q) |=> !hid_q;
  endproperty
  a_one_hidden: assert property (p_one_hidden) else $error("second hidden refresh in one period");

  // Strobes low once the second generation fall is counted
  property p_auto_low;
    @(posedge clk) disable iff (rst)
      (auto_mode && gclk_fall && falls_q == 3'(dahr_pkg::AUTO_FALL_START - 3'h1)) ##1 auto_mode
      |=> row_strobe_n == 4'h0;
  endproperty
  a_auto_low: assert property (p_auto_low) else $error("auto refresh strobes not low");

  property p_hidden_addr;
    @(posedge clk) disable iff (rst) (refresh_mode_n && hid_d) |=> dram_addr_out == $past(rcnt_q);
  endproperty
  a_hidden_addr: assert property (p_hidden_addr) else $error("counter not on address in hidden refresh");

  property p_inc;
    @(posedge clk) disable iff (rst) (req_rise && ext_mode) |=> rcnt_q == 9'($past(rcnt_q) + 9'h001);
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not increment");

  property p_we;
    @(posedge clk) disable iff (rst) (refresh_mode_n && !hid_d) |=> write_strobe_n == $past(write_request_in_n);
  endproperty
  a_we: assert property (p_we) else $error("write strobe does not follow request");

endmodule : dahr_ctrl

/* sim/dahr_dram_model.sv */
// Far side model: DRAM array latching row and column, and request pin pull-up.
// Assumes registered controller outputs, sampled on clk.
`timescale 1ns/1ps
module dahr_dram_model (
  // Clock
  input wire logic clk,
  // Controller outputs
  input wire logic [8:0] dram_addr_out,
  input wire logic [3:0] row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic refresh_request_out,
  input wire logic refresh_request_oe,
  // Observed array state
  output logic refresh_request_pin,
  output logic [8:0] cap_row,
  output logic [8:0] cap_col,
  output logic [1:0] cap_bank,
  output logic cap_write
);
  logic [3:0] rs_q; // Last row strobes
  logic cs_q; // Last column strobe
  // Open drain wire with pull-up
  assign refresh_request_pin = refresh_request_oe ? refresh_request_out : 1'b1;
  // Capture addresses on strobe falls
  always @(posedge clk) begin
    rs_q <= row_strobe_n;
    cs_q <= col_strobe_n;
    for (int b = 0; b < 4; b++) begin
      if (rs_q[b] === 1'b1 && row_strobe_n[b] === 1'b0) begin
        cap_row <= dram_addr_out;
        cap_bank <= 2'(b);
      end
    end
    if (cs_q === 1'b1 && col_strobe_n === 1'b0) begin
      cap_col <= dram_addr_out;
      cap_write <= !write_strobe_n;
    end
  end
endmodule : dahr_dram_model

/* sim/tb_dahr_ctrl.sv */
// Testbench: automatic access, hidden, requested, external and auto refresh.
// Assumes the package, controller and far side model compile first.
`timescale 1ns/1ps
module tb_dahr_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] row_in = 9'h000;
  logic [8:0] col_in = 9'h000;
  logic [1:0] bank = 2'h0;
  logic latch_en = 1'b1;
  logic req_n = 1'b1;
  logic wr_n = 1'b1;
  logic cs_n = 1'b1;
  logic hold_sel = 1'b0;
  logic pclk = 1'b1;
  logic gclk = 1'b0;
  logic mode_n = 1'b1;
  logic msel = 1'b0;
  logic [8:0] addr_o;
  logic [3:0] rs_n;
  logic col_n;
  logic wr_o;
  logic rq_o;
  logic oe;
  logic pin;
  logic [8:0] cap_row;
  logic [8:0] cap_col;
  logic [1:0] cap_bank;
  logic cap_write;
  logic [8:0] rcnt = dahr_pkg::REFRESH_COUNT_RESET; // Expected refresh row
  int error_cnt = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  dahr_ctrl dahr_ctrl_inst (.clk(clk), .rst(rst), .row_addr_in(row_in), .col_addr_in(col_in),
    .bank_sel_lo(bank[0]), .bank_sel_hi(bank[1]), .address_latch_strobe(latch_en),
    .access_request_in_n(req_n), .write_request_in_n(wr_n), .chip_select_n(cs_n),
    .row_hold_select(hold_sel), .refresh_period_clock(pclk), .refresh_gen_clock(gclk),
    .refresh_mode_n(mode_n), .refresh_mode_select(msel), .dram_addr_out(addr_o),
    .row_strobe_n(rs_n), .col_strobe_n(col_n), .write_strobe_n(wr_o),
    .refresh_request_out(rq_o), .refresh_request_oe(oe));
  dahr_dram_model dahr_dram_model_inst (.clk(clk), .dram_addr_out(addr_o), .row_strobe_n(rs_n),
    .col_strobe_n(col_n), .write_strobe_n(wr_o), .refresh_request_out(rq_o),
    .refresh_request_oe(oe), .refresh_request_pin(pin), .cap_row(cap_row), .cap_col(cap_col),
    .cap_bank(cap_bank), .cap_write(cap_write));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and run end
  task automatic end_sim;
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Compare seen against expected
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Rising edges
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  // One refresh generation clock fall
  task automatic rg_fall;
    tk(1); gclk <= 1'b1;
    tk(2); gclk <= 1'b0;
    tk(4); @(negedge clk);
  endtask : rg_fall
  ////////////////////////////////////////////////////////////////////////////
  // Automatic access, optionally with latched row
  task automatic t_access(input logic [1:0] b, input logic h, input logic w, input logic lat);
    logic [8:0] r;
    logic [8:0] c;
    int n;
    r = 9'h150 + 9'(b);
    c = 9'h0a3 - 9'(b);
    tk(1); row_in <= r; col_in <= c; bank <= b; hold_sel <= h; wr_n <= !w;
    if (lat) begin
      tk(2); latch_en <= 1'b0;
      tk(1); row_in <= ~r;
    end
    tk(1); cs_n <= 1'b0;
    tk(1); req_n <= 1'b0;
    @(negedge clk);
    n = 0;
    while (rs_n[b] !== 1'b0 && n < 10) begin @(negedge clk); n++; end
    check("row strobe delay", n, 1);
    check("bank strobes", rs_n, 4'(~(4'h1 << b)));
    check("row addr", addr_o, r);
    n = 0;
    while (col_n !== 1'b0 && n < 10) begin @(negedge clk); n++; end
    check("row hold", n, h ? dahr_pkg::ROW_HOLD_LONG_CYC : dahr_pkg::ROW_HOLD_SHORT_CYC);
    check("col addr", addr_o, c);
    check("write strobe", wr_o, !w);
    tk(1); req_n <= 1'b1;
    tk(1); @(negedge clk);
    check("strobes released", {rs_n, col_n}, 5'h1f);
    check("dram row", {cap_bank, cap_row}, {b, r});
    check("dram col", {cap_write, cap_col}, {w, c});
    tk(1); cs_n <= 1'b1; latch_en <= 1'b1;
  endtask : t_access
  // Hidden refresh, one per period, survives clock fall
  task automatic t_hidden;
    tk(1); req_n <= 1'b0;
    tk(2); @(negedge clk);
    check("hidden strobes", rs_n, 4'h0);
    check("hidden addr", addr_o, rcnt);
    tk(1); req_n <= 1'b1;
    rcnt++;
    tk(3); req_n <= 1'b0;
    tk(3); @(negedge clk);
    check("second hidden", rs_n, 4'hf);
    tk(1); req_n <= 1'b1; pclk <= 1'b0;
    tk(5); @(negedge clk);
    check("no request after hidden", pin, 1);
    tk(1); req_n <= 1'b0;
    tk(3); @(negedge clk);
    check("hidden with clock low", rs_n, 4'hf);
    tk(1); req_n <= 1'b1; pclk <= 1'b1;
    tk(3); req_n <= 1'b0;
    tk(2); pclk <= 1'b0;
    tk(3); @(negedge clk);
    check("hidden held", rs_n, 4'h0);
    check("hidden addr next", addr_o, rcnt);
    tk(1); req_n <= 1'b1;
    rcnt++;
    tk(3);
  endtask : t_hidden
  // Missed period, request, external refresh
  task automatic t_external;
    int n;
    tk(1); pclk <= 1'b1;
    tk(6); pclk <= 1'b0;
    n = 0;
    while (pin !== 1'b0 && n < 10) begin @(negedge clk); n++; end
    check("request", {pin, oe}, 2'h1);
    tk(1); mode_n <= 1'b0; msel <= dahr_pkg::REFRESH_MODE_EXTERNAL;
    tk(2); @(negedge clk);
    check("request ended", pin, 1);
    tk(1); req_n <= 1'b0;
    tk(2); @(negedge clk);
    check("external strobes", rs_n, 4'h0);
    check("external addr", addr_o, rcnt);
    tk(1); req_n <= 1'b1;
    rcnt++;
    tk(2); mode_n <= 1'b1;
    tk(4);
  endtask : t_external
  // Auto refresh, full length then cut short
  task automatic t_auto;
    tk(1); pclk <= 1'b1;
    tk(6); pclk <= 1'b0;
    tk(4); @(negedge clk);
    check("auto request", pin, 0);
    tk(1); mode_n <= 1'b0; msel <= dahr_pkg::REFRESH_MODE_AUTO;
    rg_fall;
    check("auto first fall", rs_n, 4'hf);
    check("auto addr", addr_o, rcnt);
    rg_fall;
    check("auto second fall", rs_n, 4'h0);
    check("auto request end", pin, 1);
    rg_fall;
    check("auto third fall", rs_n, 4'h0);
    rg_fall;
    check("auto fourth fall", rs_n, 4'hf);
    rcnt++;
    tk(1); mode_n <= 1'b1;
    tk(4); mode_n <= 1'b0;
    rg_fall;
    rg_fall;
    check("early low", rs_n, 4'h0);
    check("early addr", addr_o, rcnt);
    tk(1); mode_n <= 1'b1;
    tk(3); @(negedge clk);
    check("early end", rs_n, 4'hf);
  endtask : t_auto
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    tk(5000);
    error_cnt++;
    end_sim();
  end
  // Main sequence
  initial begin
    tk(3); rst <= 1'b0;
    @(negedge clk);
    check("reset outputs", {rs_n, col_n, wr_o, oe, addr_o}, 16'hfc00);
    check("reset pin", pin, 1);
    for (int b = 0; b < 4; b++) t_access(2'(b), b[0], b[1], b == 3);
    check("no request clock high", pin, 1);
    t_hidden();
    t_external();
    t_auto();
    end_sim();
  end
endmodule : tb_dahr_ctrl
